// ==== src/iot_cfg.svh ====
/*
 * constants of the i/o translation buffer maintenance block: register
 * offsets, command and mode codes, field positions and counts.
 * assumes it is included by bare name from the package and the modules.
 */
`ifndef IOT_CFG_SVH
`define IOT_CFG_SVH

// ****************
// register offsets (byte addresses, one aligned word each)
// ****************
`define IOT_OFF_COMMAND   12'h000
`define IOT_OFF_ENTRY_L   12'h004
`define IOT_OFF_ENTRY_M   12'h008
`define IOT_OFF_MASK      12'h00c
`define IOT_OFF_PDIR_BASE 12'h010
`define IOT_OFF_MODE      12'h014
`define IOT_OFF_STATUS    12'h018
`define IOT_OFF_MSB       11

// ****************
// command register fields and codes
// ****************
`define IOT_CMD_OP_MSB    26
`define IOT_CMD_OP_LSB    24
`define IOT_OP_PURGE      3'h1
`define IOT_OP_INSERT     3'h2
`define IOT_OP_DIRECT     3'h3
`define IOT_OP_RESET      3'h4

// ****************
// translation modes
// ****************
`define IOT_MODE_REAL     2'h0
`define IOT_MODE_NODIR    2'h1
`define IOT_MODE_FETCH    2'h2

// ****************
// status bits
// ****************
`define IOT_ST_READY      0
`define IOT_ST_HARD_ERR   1
`define IOT_ST_BUSY       2

// ****************
// sizes, fields and counts
// ****************
`define IOT_PN_W          20
`define IOT_PG_LSB        12
`define IOT_IDX_W         8
`define IOT_RAM_DEPTH     256
`define IOT_VALID_BIT     0
`define IOT_ENT_SHIFT     3
`define IOT_TRANSIT       8'd8

`endif

// ==== src/iot_pkg.sv ====
/*
 * types of the i/o translation buffer maintenance block.
 * assumes iot_cfg.svh is on the include path.
 */
`include "iot_cfg.svh"

package iot_pkg;

    // engine states
    typedef enum logic [1:0] {
        ST_IDLE, ST_TRANSIT, ST_EXEC, ST_FETCH
    } iot_eng_t;

    // apb request from the processor side
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } iot_apb_req_t;

    // apb answer
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } iot_apb_rsp_t;

    // translation request from the i/o bus side
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
    } iot_io_req_t;

    // translation answer
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [63:0] entry;
    } iot_io_rsp_t;

    // directory read towards main memory
    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } iot_mem_req_t;

    typedef struct packed {
        logic        ack;
        logic [63:0] data;
    } iot_mem_rsp_t;

    // one buffer line: full page number tag and entry
    typedef struct packed {
        logic [`IOT_PN_W-1:0] tag;
        logic [63:0]          entry;
    } iot_line_t;

    // buffer write port
    typedef struct packed {
        logic                  we;
        logic [`IOT_IDX_W-1:0] idx;
        iot_line_t             line;
    } iot_ram_wr_t;

    // whole state of the top module
    typedef struct packed {
        iot_apb_rsp_t         apb;
        iot_io_rsp_t          io;
        iot_mem_req_t         mem;
        logic [31:0]          entry_l;
        logic [31:0]          entry_m;
        logic [31:0]          mask;
        logic [31:0]          base;
        logic [1:0]           mode;
        logic                 hard_err;
        logic                 cmd_pend;
        logic [2:0]           cmd_op;
        logic [`IOT_PN_W-1:0] cmd_pn;
        logic [7:0]           cnt;
        iot_eng_t             eng;
        logic                 from_miss;
        logic                 retry;
        logic [`IOT_PN_W-1:0] fetch_pn;
        iot_ram_wr_t          ram_wr;
    } iot_state_t;

endpackage

// ==== src/iot_entry_ram.sv ====
/*
 * flip-flop storage of the translation buffer: 256 lines of tag and
 * entry, one write port, one asynchronous read port.
 * assumes a single clock; contents are not reset, like a real ram.
 */
`include "iot_cfg.svh"

module iot_entry_ram (
    // clock
    input  wire logic                   mclk,
    // write port
    input  wire iot_pkg::iot_ram_wr_t   wr,
    // read port
    input  wire logic [`IOT_IDX_W-1:0]  rd_idx,
    output      iot_pkg::iot_line_t     rd_line
);
    import iot_pkg::*;

    // ****************
    // storage
    // ****************
    typedef struct packed {
        iot_line_t [`IOT_RAM_DEPTH-1:0] line;
    } iot_ram_t;

    iot_ram_t q;   // stored lines
    iot_ram_t d;   // next lines

    // write one line per cycle when enabled
    always_comb begin
        d = q;
        if (wr.we) begin
            d.line[wr.idx] = wr.line;
        end
    end

    // no reset: power-on contents stay random until software clears them
    always_ff @(posedge mclk) begin
        q <= d;
    end

    // read is combinational off the flops
    assign rd_line = q.line[rd_idx];

endmodule

// ==== src/iot_top.sv ====
/*
 * i/o adapter translation buffer maintenance: apb register file,
 * purge / insert / explicit write commands, lookup for i/o bus
 * transactions, fetch-on-miss from the page directory and hard error.
 * assumes a 20 mhz mclk, a memory port that answers a directory read
 * with a one-cycle ack, and an i/o side that holds its request until
 * it sees ack or err.
 */
// Decided for this implementation: the register addresses and the APB register port.
// Functional notes
// - three commands: purge, insert, explicit write
// - purge invalidates only valid fully matching entry
// - insert reads translation from page directory
// - index from page number; base plus page
// - explicit write stores staging entry, page tag
// - explicit write initialises ram, loads no-directory
// - ready only after explicit write completed
// - all-zero staging entry is not valid
// - fetch mode miss reads page directory
// - invalid fetched entry: hard error, block dma
// - index mask selects address bits for index
// - no-directory miss logs error, no fetch
// - index occupies exactly the set mask bits
// - commands pass both queues, take cycles
// - base, mask, mode writes take effect immediately
`include "iot_cfg.svh"

module iot_top (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // apb register bus
    input  wire iot_pkg::iot_apb_req_t apb_req,
    output      iot_pkg::iot_apb_rsp_t apb_rsp,
    // i/o bus translation requests
    input  wire iot_pkg::iot_io_req_t  io_req,
    output      iot_pkg::iot_io_rsp_t  io_rsp,
    // page directory reads
    output      iot_pkg::iot_mem_req_t mem_req,
    input  wire iot_pkg::iot_mem_rsp_t mem_rsp
);
    import iot_pkg::*;

    // ****************
    // helpers
    // ****************

    // pack the page bits under set mask bits into the index, low first
    function automatic logic [`IOT_IDX_W-1:0] idx_of(
        input logic [`IOT_PN_W-1:0] m,
        input logic [`IOT_PN_W-1:0] pn
    );
        logic [`IOT_IDX_W-1:0] r;
        logic [3:0]            k;
        r = '0;
        k = '0;
        for (int i = 0; i < `IOT_PN_W; i++) begin
            if (m[i] && (k < 4'(`IOT_IDX_W))) begin
                r[k[2:0]] = pn[i];
                k = k + 4'h1;
            end
        end
        return r;
    endfunction

    // a line hits when valid and the whole page number matches
    function automatic logic hit_of(
        input iot_line_t            l,
        input logic [`IOT_PN_W-1:0] pn
    );
        return l.entry[`IOT_VALID_BIT] && (l.tag == pn);
    endfunction

    // ****************
    // reset release
    // ****************
    logic [1:0] rst_sync_q;   // two-stage release of reset_n
    logic       rst_n;        // synchronised reset for the block

    // release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************
    // state and buffer
    // ****************
    iot_state_t            q;         // registered state
    iot_state_t            d;         // next state
    iot_line_t             rd_line;   // line at rd_idx
    logic [`IOT_IDX_W-1:0] rd_idx;    // buffer read index
    logic [`IOT_PN_W-1:0]  io_pn;     // page number of i/o request
    logic [`IOT_PN_W-1:0]  mask_pn;   // mask bits over the page number
    logic [`IOT_OFF_MSB:0] off;       // decoded register offset
    logic                  map_ok;    // offset is a register

    iot_entry_ram u_ram (
        .mclk    (mclk),
        .wr      (q.ram_wr),
        .rd_idx  (rd_idx),
        .rd_line (rd_line)
    );

    assign io_pn   = io_req.addr[31:`IOT_PG_LSB];
    assign mask_pn = q.mask[31:`IOT_PG_LSB];
    assign off     = apb_req.paddr[`IOT_OFF_MSB:0];

    // the mask picks which address bits index the buffer
    assign rd_idx = (q.eng == ST_EXEC) ? idx_of(mask_pn, q.cmd_pn)
                                       : idx_of(mask_pn, io_pn);

    // offsets that hold a register
    always_comb begin
        unique case (off)
            `IOT_OFF_COMMAND, `IOT_OFF_ENTRY_L, `IOT_OFF_ENTRY_M,
            `IOT_OFF_MASK, `IOT_OFF_PDIR_BASE, `IOT_OFF_MODE,
            `IOT_OFF_STATUS: map_ok = 1'b1;
            default:         map_ok = 1'b0;
        endcase
    end

    // ****************
    // next state
    // ****************
    always_comb begin
        d = q;
        d.ram_wr.we = 1'b0;
        d.io.ack    = 1'b0;
        d.io.err    = 1'b0;

        // apb first access cycle: decide answer, one wait state
        if (apb_req.psel && apb_req.penable && !q.apb.pready) begin
            d.apb.pready  = 1'b1;
            d.apb.pslverr = !map_ok;
            d.apb.prdata  = 32'h0;
            if (!apb_req.pwrite) begin
                unique case (off)
                    `IOT_OFF_ENTRY_L:   d.apb.prdata = q.entry_l;
                    `IOT_OFF_ENTRY_M:   d.apb.prdata = q.entry_m;
                    `IOT_OFF_MASK:      d.apb.prdata = q.mask;
                    `IOT_OFF_PDIR_BASE: d.apb.prdata = q.base;
                    `IOT_OFF_MODE:      d.apb.prdata = {30'h0, q.mode};
                    `IOT_OFF_STATUS: begin
                        // ready drops while any command is in flight
                        d.apb.prdata[`IOT_ST_READY]    = !q.cmd_pend;
                        d.apb.prdata[`IOT_ST_HARD_ERR] = q.hard_err;
                        d.apb.prdata[`IOT_ST_BUSY] = q.eng != ST_IDLE;
                    end
                    default:            d.apb.prdata = 32'h0;
                endcase
            end else if (off == `IOT_OFF_COMMAND) begin
                // one buffer command in flight; reset is always taken, unknown codes refused
                unique case (apb_req.pwdata[`IOT_CMD_OP_MSB:
                                            `IOT_CMD_OP_LSB])
                    `IOT_OP_PURGE, `IOT_OP_INSERT, `IOT_OP_DIRECT:
                        d.apb.pslverr = q.cmd_pend;
                    `IOT_OP_RESET: d.apb.pslverr = 1'b0;
                    default:       d.apb.pslverr = 1'b1;
                endcase
            end
        end else if (q.apb.pready) begin
            // completing edge: writes take effect here
            d.apb.pready  = 1'b0;
            d.apb.pslverr = 1'b0;
            if (apb_req.pwrite && !q.apb.pslverr) begin
                unique case (off)
                    `IOT_OFF_ENTRY_L:   d.entry_l = apb_req.pwdata;
                    `IOT_OFF_ENTRY_M:   d.entry_m = apb_req.pwdata;
                    // control writes bypass the queues
                    `IOT_OFF_MASK:      d.mask = apb_req.pwdata;
                    `IOT_OFF_PDIR_BASE: d.base = apb_req.pwdata;
                    `IOT_OFF_MODE:
                        d.mode = apb_req.pwdata[1:0];
                    `IOT_OFF_COMMAND: begin
                        if (apb_req.pwdata[`IOT_CMD_OP_MSB:
                                `IOT_CMD_OP_LSB] == `IOT_OP_RESET) begin
                            d.hard_err = 1'b0;
                        end else begin
                            d.cmd_pend = 1'b1;
                            d.cmd_op   = apb_req.pwdata[
                                `IOT_CMD_OP_MSB:`IOT_CMD_OP_LSB];
                            d.cmd_pn   = apb_req.pwdata[`IOT_PN_W-1:0];
                        end
                    end
                    default: d.mode = q.mode;   // status is read only
                endcase
            end
        end

        // translation engine
        unique case (q.eng)
            ST_IDLE: begin
                if (q.cmd_pend) begin
                    // queue traversal delay before the buffer changes
                    d.eng = ST_TRANSIT;
                    d.cnt = `IOT_TRANSIT;
                end else if (io_req.valid && !q.io.ack && !q.io.err &&
                             !q.ram_wr.we) begin
                    // a line still being written would read stale here
                    if (q.hard_err) begin
                        d.io.err = 1'b1;        // dma blocked
                    end else if (q.mode != `IOT_MODE_NODIR &&
                                 q.mode != `IOT_MODE_FETCH) begin
                        // real mode: identity, buffer untouched
                        d.io.ack   = 1'b1;
                        d.io.entry = {32'h0, io_req.addr};
                    end else if (hit_of(rd_line, io_pn)) begin
                        d.io.ack   = 1'b1;
                        d.io.entry = rd_line.entry;
                        d.retry    = 1'b0;
                    end else if (q.mode == `IOT_MODE_FETCH && !q.retry) begin
                        // miss: go read the directory entry
                        d.eng       = ST_FETCH;
                        d.from_miss = 1'b1;
                        d.fetch_pn  = io_pn;
                        d.mem.req   = 1'b1;
                        d.mem.addr  = q.base + {9'h0, io_pn,
                                               `IOT_ENT_SHIFT'h0};
                    end else begin
                        // no-directory miss, or refetch still misses
                        d.hard_err = 1'b1;
                        d.io.err   = 1'b1;
                        d.retry    = 1'b0;
                    end
                end
            end
            ST_TRANSIT: begin
                d.cnt = q.cnt - 8'h1;
                if (q.cnt == 8'h1) begin
                    d.eng = ST_EXEC;
                end
            end
            ST_EXEC: begin
                d.eng = ST_IDLE;
                unique case (q.cmd_op)
                    `IOT_OP_PURGE: begin
                        // only a valid full match is cleared
                        if (hit_of(rd_line, q.cmd_pn)) begin
                            d.ram_wr.we   = 1'b1;
                            d.ram_wr.idx  = rd_idx;
                            d.ram_wr.line = '0;
                        end
                        d.cmd_pend = 1'b0;
                    end
                    `IOT_OP_INSERT: begin
                        d.eng       = ST_FETCH;
                        d.from_miss = 1'b0;
                        d.fetch_pn  = q.cmd_pn;
                        d.mem.req   = 1'b1;
                        d.mem.addr  = q.base + {9'h0, q.cmd_pn,
                                               `IOT_ENT_SHIFT'h0};
                    end
                    default: begin
                        // explicit write of the staging pair
                        d.ram_wr.we   = 1'b1;
                        d.ram_wr.idx  = rd_idx;
                        d.ram_wr.line = {q.cmd_pn, q.entry_m, q.entry_l};
                        d.cmd_pend    = 1'b0;
                    end
                endcase
            end
            ST_FETCH: begin
                // hold the read until memory answers
                if (mem_rsp.ack) begin
                    d.mem.req     = 1'b0;
                    d.ram_wr.we   = 1'b1;
                    d.ram_wr.idx  = idx_of(mask_pn, q.fetch_pn);
                    d.ram_wr.line = {q.fetch_pn, mem_rsp.data};
                    d.eng         = ST_IDLE;
                    if (q.from_miss) begin
                        d.retry = 1'b1;   // look again; invalid is error
                    end else begin
                        d.cmd_pend = 1'b0;
                    end
                end
            end
        endcase
    end

    // ****************
    // state register
    // ****************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q     <= '0;
            q.eng <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign apb_rsp = q.apb;
    assign io_rsp  = q.io;
    assign mem_req = q.mem;

endmodule

// ==== dv/iot_top_checker.sv ====
/*
 * concurrent checks on the ports of iot_top.
 * assumes one clock, reset_n active low, bound into iot_top below.
 */
`include "iot_cfg.svh"

module iot_top_checker (
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  reset_n,
    // register bus
    input wire iot_pkg::iot_apb_req_t apb_req,
    input wire iot_pkg::iot_apb_rsp_t apb_rsp,
    // i/o side
    input wire iot_pkg::iot_io_req_t  io_req,
    input wire iot_pkg::iot_io_rsp_t  io_rsp,
    // directory side
    input wire iot_pkg::iot_mem_req_t mem_req,
    input wire iot_pkg::iot_mem_rsp_t mem_rsp
);
    import iot_pkg::*;
    // ****************
    // helpers
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // completing bus edge, command write and its opcode
    wire       xfer_w = apb_req.psel & apb_req.penable & apb_rsp.pready;
    wire       cmd_w  = xfer_w & apb_req.pwrite &
                        (apb_req.paddr[11:0] == `IOT_OFF_COMMAND);
    wire [2:0] op_w   = apb_req.pwdata[`IOT_CMD_OP_MSB:`IOT_CMD_OP_LSB];
    wire       fin_w  = mem_req.req & mem_rsp.ack & io_req.valid;
    // cycles since a buffer command was taken; saturates so it never wraps
    logic [7:0] since_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            since_q <= 8'hff;
        end else if (cmd_w && !apb_rsp.pslverr && op_w inside {1, 2, 3}) begin
            since_q <= 8'h00;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
        end
    end
    // ****************
    // assertions
    // ****************
    AST_APB_WAIT: assert property (
        apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready not in second access cycle");
    AST_APB_PULSE: assert property (
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    AST_BAD_OP: assert property (
        cmd_w && (op_w == 3'h0 || op_w > 3'h4) |-> apb_rsp.pslverr)
        else $error("unknown opcode accepted");
    AST_MEM_HOLD: assert property (
        mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req.addr))
        else $error("directory read dropped or moved early");
    AST_MEM_DROP: assert property (
        mem_req.req && mem_rsp.ack |=> !mem_req.req)
        else $error("directory read held after ack");
    AST_ACK_ERR: assert property (
        !(io_rsp.ack && io_rsp.err))
        else $error("ack and err together");
    AST_FETCH_OK: assert property (
        fin_w && mem_rsp.data[`IOT_VALID_BIT] |-> ##[1:3] io_rsp.ack)
        else $error("valid fetched entry not answered");
    AST_FETCH_BAD: assert property (
        fin_w && !mem_rsp.data[`IOT_VALID_BIT] |-> ##[1:3] io_rsp.err)
        else $error("invalid fetched entry without error");
    AST_NOT_READY: assert property (
        xfer_w && !apb_req.pwrite && since_q < 8'd9 &&
        apb_req.paddr[11:0] == `IOT_OFF_STATUS
        |-> !apb_rsp.prdata[`IOT_ST_READY])
        else $error("ready shown before entry stored");
    // main scenarios
    CV_ACK: cover property (io_rsp.ack);
    CV_ERR: cover property (io_rsp.err);
    CV_FETCH: cover property (fin_w);
    CV_REFUSE: cover property (xfer_w && apb_rsp.pslverr);
endmodule

bind iot_top iot_top_checker u_chk (.mclk(mclk), .reset_n(reset_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .io_req(io_req),
    .io_rsp(io_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp));

// ==== dv/iot_mem_model.sv ====
/*
 * main memory holding the page directory, answering one read at a time.
 * assumes the bench fills dir and sets the answer delay lat.
 */
module iot_mem_model (
    // clock
    input  wire logic                  mclk,
    // directory read port
    input  wire iot_pkg::iot_mem_req_t mem_req,
    output      iot_pkg::iot_mem_rsp_t mem_rsp,
    // answer delay in cycles
    input  wire logic [3:0]            lat
);
    import iot_pkg::*;
    logic [63:0] dir [logic [31:0]]; // kept valid by the bench
    logic [3:0]  wait_q = 4'h0;      // cycles waited on this read
    initial mem_rsp = '0;
    // answer after lat cycles; idle data toggles so no stale value lingers
    always @(posedge mclk) begin
        if (mem_req.req && !mem_rsp.ack && wait_q >= lat) begin
            mem_rsp.ack  <= 1'b1;
            mem_rsp.data <= dir.exists(mem_req.addr) ? dir[mem_req.addr] : '0;
            wait_q       <= 4'h0;
        end else begin
            mem_rsp.ack  <= 1'b0;
            mem_rsp.data <= ~mem_rsp.data;
            wait_q       <= (mem_req.req && !mem_rsp.ack) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

// ==== dv/tb_io_tlb_command_and_init.sv ====
/*
 * self-checking bench of iot_top: register bus, buffer commands, lookups.
 * assumes iot_mem_model as directory memory and the bound checker.
 */
`include "iot_cfg.svh"

module tb_io_tlb_command_and_init;
    timeunit 1ns;
    timeprecision 1ns;
    import iot_pkg::*;
    // ****************
    // signals, design and memory
    // ****************
    logic         mclk = 1'b0;
    logic         reset_n = 1'b0;
    iot_apb_req_t apb_req = '0;
    iot_apb_rsp_t apb_rsp;
    iot_io_req_t  io_req = '0;
    iot_io_rsp_t  io_rsp;
    iot_mem_req_t mem_req;
    iot_mem_rsp_t mem_rsp;
    logic [3:0]   lat = 4'h0;   // memory answer delay
    logic [31:0]  mem_addr;     // address of the last directory read
    int           fetches, mismatches, n_compared;
    localparam logic [31:0] BASE = 32'h0010_0000;
    localparam logic [63:0] E4 = 64'hcafe_0000_0000_0b01;
    always #25 mclk = ~mclk;
    iot_top DUT (.mclk(mclk), .reset_n(reset_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .io_req(io_req), .io_rsp(io_rsp),
        .mem_req(mem_req), .mem_rsp(mem_rsp));
    iot_mem_model u_mem (.mclk(mclk), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .lat(lat));
    // count finished directory reads
    always @(posedge mclk) begin
        if (mem_req.req && mem_rsp.ack) begin
            fetches  <= fetches + 1;
            mem_addr <= mem_req.addr;
        end
    end
    task automatic check(string w, logic [63:0] e, logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    // one transfer; holds the request until pready is sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                       output logic [31:0] r, output logic s);
        int n;
        @(posedge mclk);
        apb_req <= '{1'b1, 1'b0, w, {20'h0, a}, d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        r = apb_rsp.prdata;
        s = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, logic e = 1'b0);
        logic [31:0] r;
        logic        s;
        apb(1'b1, a, d, r, s);
        check("pslverr", {63'h0, e}, {63'h0, s});
    endtask
    task automatic rd(logic [11:0] a, output logic [31:0] r);
        logic s;
        apb(1'b0, a, 32'h0, r, s);
    endtask
    task automatic wait_ready();
        logic [31:0] r;
        int          n;
        n = 0;
        do begin
            rd(`IOT_OFF_STATUS, r);
            n++;
        end while (r[`IOT_ST_READY] !== 1'b1 && n < 50);
        check("ready", 64'h1, {63'h0, r[`IOT_ST_READY]});
    endtask
    function automatic logic [31:0] cw(logic [2:0] op, logic [19:0] pn);
        return {5'h0, op, 4'h0, pn};
    endfunction
    task automatic cmd(logic [2:0] op, logic [19:0] pn);
        wr(`IOT_OFF_COMMAND, cw(op, pn));
        if (op != `IOT_OP_RESET) wait_ready();
    endtask
    task automatic mode(logic [1:0] m);
        wr(`IOT_OFF_MODE, {30'h0, m});
    endtask
    // one lookup; waits for ack or err under a bound
    task automatic io(logic [31:0] a, logic ee, logic [63:0] e);
        int n;
        @(posedge mclk);
        io_req <= '{1'b1, a};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (io_rsp.ack !== 1'b1 && io_rsp.err !== 1'b1 && n < 100);
        check("io err", {63'h0, ee}, {63'h0, io_rsp.err});
        if (!ee) check("io entry", e, io_rsp.entry);
        io_req <= '0;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_setup();
        wr(12'h01c, 32'h0, 1'b1);
        wr(`IOT_OFF_COMMAND, 32'h0500_0000, 1'b1);
        wr(`IOT_OFF_MASK, 32'hff00_0000);
        wr(`IOT_OFF_PDIR_BASE, BASE);
        mode(`IOT_MODE_FETCH);
        wr(`IOT_OFF_ENTRY_L, 32'h0);
        wr(`IOT_OFF_ENTRY_M, 32'h0);
        for (int i = 0; i < `IOT_RAM_DEPTH; i++) begin
            cmd(`IOT_OP_DIRECT, {i[7:0], 12'h0});
        end
        $display("setup done");
    endtask
    task automatic t_nodir();
        logic [31:0] r;
        int          f;
        mode(`IOT_MODE_NODIR);
        wr(`IOT_OFF_ENTRY_L, 32'h0000_a001);
        wr(`IOT_OFF_ENTRY_M, 32'h1234_5678);
        wr(`IOT_OFF_COMMAND, cw(`IOT_OP_DIRECT, 20'h05123));
        rd(`IOT_OFF_STATUS, r);
        check("early", 64'h0, {63'h0, r[`IOT_ST_READY]});
        wr(`IOT_OFF_COMMAND, cw(`IOT_OP_PURGE, 20'h05123), 1'b1);
        wait_ready();
        io(32'h0512_30ab, 1'b0, 64'h1234_5678_0000_a001);
        cmd(`IOT_OP_PURGE, 20'h05456);
        io(32'h0512_3000, 1'b0, 64'h1234_5678_0000_a001);
        cmd(`IOT_OP_PURGE, 20'h05123);
        f = fetches;
        io(32'h0512_3000, 1'b1, 64'h0);
        check("fetches", 64'(f), 64'(fetches));
        rd(`IOT_OFF_STATUS, r);
        check("hard", 64'h1, {63'h0, r[`IOT_ST_HARD_ERR]});
        cmd(`IOT_OP_RESET, 20'h0);
        io(32'h0900_0000, 1'b1, 64'h0);
        cmd(`IOT_OP_RESET, 20'h0);
        $display("no-directory done");
    endtask
    task automatic t_fetch();
        int f;
        u_mem.dir[BASE + 32'h0005_0020] = E4;
        u_mem.dir[BASE + 32'h0005_8028] = 64'h0000_beef_0000_0c01;
        mode(`IOT_MODE_FETCH);
        f = fetches;
        io(32'h0a00_4010, 1'b0, E4);
        check("addr", {32'h0, BASE + 32'h0005_0020}, {32'h0, mem_addr});
        io(32'h0a00_4000, 1'b0, E4);
        check("count", 64'(f + 1), 64'(fetches));
        lat <= 4'h6;
        cmd(`IOT_OP_INSERT, 20'h0b005);
        mode(`IOT_MODE_NODIR);
        io(32'h0b00_5000, 1'b0, 64'h0000_beef_0000_0c01);
        mode(`IOT_MODE_FETCH);
        io(32'h0c00_6000, 1'b1, 64'h0);
        io(32'h0a00_4000, 1'b1, 64'h0);
        cmd(`IOT_OP_RESET, 20'h0);
        io(32'h0a00_4000, 1'b0, E4);
        mode(`IOT_MODE_REAL);
        io(32'h0123_4000, 1'b0, 64'h0123_4000);
        $display("fetch done");
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_setup();
        t_nodir();
        t_fetch();
        summarize();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        summarize();
    end
endmodule
